/* common/cct_pkg.sv */
package cct_pkg;

  // counter and credit width, wide enough for 4096-byte requests
  localparam int CCT_CW        = 13;
  localparam int CCT_TAG_W     = 5;
  localparam int CCT_TAGS      = 32;

  // completion space reserved by the endpoint
  localparam logic [12:0] CCT_TOTAL_HDR       = 13'h0040;
  localparam int          CCT_TOTAL_DATA_B    = 15872;
  localparam int          CCT_CREDIT_BYTES    = 16;
  localparam logic [3:0]  CCT_CREDIT_LOG2     = 4'h4;

  // completion boundary and request size encodings
  localparam logic [3:0]  CCT_RCB64_LOG2      = 4'h6;
  localparam logic [3:0]  CCT_RCB128_LOG2     = 4'h7;
  localparam logic [3:0]  CCT_MRS_BASE_LOG2   = 4'h7;
  localparam logic [2:0]  CCT_MRS_MAX_CODE    = 3'h5;
  localparam int          CCT_MRS_MSB         = 14;
  localparam int          CCT_MRS_LSB         = 12;
  localparam logic [12:0] CCT_MAX_CPL_BYTES   = 13'h1000;

  typedef enum logic [3:0] {
    request_limit_method   = 4'b0001,
    per_packet_method      = 4'b0010,
    per_boundary_method    = 4'b0100,
    per_data_credit_method = 4'b1000
  } cct_method_e;

  typedef enum logic [2:0] {
    cct_mem_read = 3'b001,
    cct_io_read  = 3'b010,
    cct_io_write = 3'b100
  } cct_kind_e;

  typedef struct packed {
    logic [12:0] hdr;
    logic [12:0] data;
    cct_kind_e   kind;
  } cct_entry_s;

  typedef struct packed {
    cct_entry_s [CCT_TAGS-1:0] ent;
  } cct_table_s;

  typedef struct packed {
    logic [12:0] outstanding_request_count;
    logic [12:0] request_limit;
    logic [12:0] pending_header_credits;
    logic [12:0] pending_data_credits;
    logic [3:0]  rcb_log2;
    logic [3:0]  mrs_log2;
  } cct_top_s;

  localparam cct_top_s CCT_TOP_RST = '{
    outstanding_request_count: 13'h0000,
    request_limit:             13'h0000,
    pending_header_credits:    13'h0000,
    pending_data_credits:      13'h0000,
    rcb_log2:                  CCT_RCB64_LOG2,
    mrs_log2:                  CCT_MRS_BASE_LOG2
  };

endpackage : cct_pkg

/* common/cct_tag_if.sv */
`timescale 1ns/1ps
interface cct_tag_if;
  import cct_pkg::*;
  logic                 wr_en;
  logic [CCT_TAG_W-1:0] wr_tag;
  logic [12:0]          wr_hdr;
  logic [12:0]          wr_data;
  cct_kind_e            wr_kind;
  logic [CCT_TAG_W-1:0] rd_tag;
  logic [12:0]          rd_hdr;
  logic [12:0]          rd_data;
  cct_kind_e            rd_kind;

  modport tracker (output wr_en, wr_tag, wr_hdr, wr_data, wr_kind, rd_tag,
                   input  rd_hdr, rd_data, rd_kind);
  modport store   (input  wr_en, wr_tag, wr_hdr, wr_data, wr_kind, rd_tag,
                   output rd_hdr, rd_data, rd_kind);
endinterface : cct_tag_if

/* rtl/cct_block_count.sv */
`timescale 1ns/1ps
module cct_block_count (
  input  wire logic [11:0] start_addr,
  input  wire logic [12:0] size_bytes,
  input  wire logic [3:0]  gran_log2,
  output logic      [12:0] blocks
);
  logic [13:0] mask;
  logic [13:0] sum;

  // ceiling of ((start mod gran) + size) / gran, gran a power of two
  always_comb begin
    mask   = 14'((14'h0001 << gran_log2) - 14'h0001);
    sum    = ({2'h0, start_addr} & mask) + {1'b0, size_bytes} + mask;
    blocks = 13'(sum >> gran_log2);
  end
endmodule : cct_block_count

/* rtl/cct_tag_table.sv */
`timescale 1ns/1ps
module cct_tag_table
  import cct_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  cct_tag_if.store  tag
);
  cct_table_s st;
  cct_table_s next_st;

  // read is combinational so a completion can release in its own cycle
  always_comb begin
    next_st = st;
    if (tag.wr_en) begin
      next_st.ent[tag.wr_tag] = '{hdr: tag.wr_hdr, data: tag.wr_data, kind: tag.wr_kind};
    end
    tag.rd_hdr  = st.ent[tag.rd_tag].hdr;
    tag.rd_data = st.ent[tag.rd_tag].data;
    tag.rd_kind = st.ent[tag.rd_tag].kind;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : cct_tag_table

/* rtl/cct_tracker.sv */
`timescale 1ns/1ps
module cct_tracker
  import cct_pkg::*;
#(
  parameter cct_method_e METHOD          = per_packet_method,
  parameter bit          USE_CFG_RCB     = 1'b1,
  parameter bit          USE_CFG_MRS     = 1'b1,
  parameter int          FUNC_SEL        = 0,
  parameter int          DATA_SCALE_LOG2 = 0,
  parameter bit          IO_CREDIT_RULE  = 1'b1
) (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic [1:0]                    cfg_rcb_status,
  input  wire logic [15:0]                   cfg_dcommand,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  output logic                               req_sent,
  input  wire logic [11:0]                   req_addr,
  input  wire logic [12:0]                   req_size,
  input  wire cct_pkg::cct_kind_e            req_kind,
  input  wire logic [cct_pkg::CCT_TAG_W-1:0] req_tag,
  input  wire logic                          cpl_valid,
  input  wire logic [cct_pkg::CCT_TAG_W-1:0] cpl_tag,
  input  wire logic [6:0]                    cpl_lower_addr,
  input  wire logic [10:0]                   cpl_length_dw,
  input  wire logic                          cpl_has_data,
  input  wire logic                          cpl_final,
  output logic      [cct_pkg::CCT_CW-1:0]    outstanding_request_count,
  output logic      [cct_pkg::CCT_CW-1:0]    request_limit,
  output logic      [cct_pkg::CCT_CW-1:0]    pending_header_credits,
  output logic      [cct_pkg::CCT_CW-1:0]    pending_data_credits
);
  import cct_pkg::*;

  // finer data credit units divide the 16-byte credit by 2 or 4
  localparam logic [3:0]  GRAN_LOG2  = 4'(CCT_CREDIT_LOG2 - 4'(DATA_SCALE_LOG2));
  localparam logic [12:0] TOTAL_DATA = 13'((CCT_TOTAL_DATA_B / CCT_CREDIT_BYTES) << DATA_SCALE_LOG2);

  cct_top_s    st;
  cct_top_s    next_st;
  cct_tag_if   tag ();

  logic [12:0] req_hdr_blocks;
  logic [12:0] req_data_blocks;
  logic [12:0] cpl_hdr_blocks;
  logic [12:0] cpl_data_blocks;
  logic [12:0] cpl_bytes;
  logic [12:0] need_hdr;
  logic [12:0] need_data;
  logic [12:0] rel_hdr;
  logic [12:0] rel_data;
  logic [3:0]  dpb_log2;
  logic [3:0]  hpr_log2;
  logic [12:0] data_pool_lim;
  logic [12:0] hdr_pool_lim;
  logic        room_ok;
  logic        limit_release;
  logic [2:0]  mrs_code;

  function automatic logic [12:0] cct_sat_sub(input logic [13:0] a, input logic [12:0] b);
    logic [13:0] bb;
    bb = {1'b0, b};
    cct_sat_sub = (a > bb) ? 13'(a - bb) : 13'h0000;
  endfunction : cct_sat_sub

  cct_block_count u_req_hdr (
    .start_addr (req_addr),
    .size_bytes (req_size),
    .gran_log2  (st.rcb_log2),
    .blocks     (req_hdr_blocks)
  );
  cct_block_count u_req_data (
    .start_addr (req_addr),
    .size_bytes (req_size),
    .gran_log2  (GRAN_LOG2),
    .blocks     (req_data_blocks)
  );
  cct_block_count u_cpl_hdr (
    .start_addr ({5'h00, cpl_lower_addr}),
    .size_bytes (cpl_bytes),
    .gran_log2  (st.rcb_log2),
    .blocks     (cpl_hdr_blocks)
  );
  cct_block_count u_cpl_data (
    .start_addr ({5'h00, cpl_lower_addr}),
    .size_bytes (cpl_bytes),
    .gran_log2  (GRAN_LOG2),
    .blocks     (cpl_data_blocks)
  );

  cct_tag_table u_tags (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tag      (tag)
  );

  assign mrs_code = cfg_dcommand[CCT_MRS_MSB:CCT_MRS_LSB];

  // a length of zero dwords encodes the largest completion
  assign cpl_bytes = (cpl_length_dw == 11'h000) ? CCT_MAX_CPL_BYTES : {cpl_length_dw, 2'b00};

  always_comb begin
    dpb_log2      = 4'(st.rcb_log2 - GRAN_LOG2);
    hpr_log2      = 4'(st.mrs_log2 - st.rcb_log2);
    data_pool_lim = 13'(TOTAL_DATA >> (st.mrs_log2 - GRAN_LOG2));
    hdr_pool_lim  = 13'(CCT_TOTAL_HDR >> hpr_log2);
    need_hdr      = req_hdr_blocks;
    need_data     = (req_kind == cct_io_write) ? 13'h0000 : req_data_blocks;
    if (METHOD == per_boundary_method) begin
      need_data = 13'(req_hdr_blocks << dpb_log2);
      if (IO_CREDIT_RULE && req_kind == cct_io_read) begin
        need_data = 13'h0001;
      end else if (IO_CREDIT_RULE && req_kind == cct_io_write) begin
        need_data = 13'h0000;
      end
    end
    room_ok = (({1'b0, st.pending_header_credits} + {1'b0, need_hdr}) < {1'b0, CCT_TOTAL_HDR}) &&
              (({1'b0, st.pending_data_credits} + {1'b0, need_data}) < {1'b0, TOTAL_DATA});
    if (METHOD == request_limit_method) begin
      req_ready = st.outstanding_request_count < st.request_limit;
    end else begin
      req_ready = room_ok;
    end
    req_sent = req_valid && req_ready;
  end

  // credit release for the completion seen in this cycle
  always_comb begin
    rel_hdr       = 13'h0000;
    rel_data      = 13'h0000;
    limit_release = cpl_valid && cpl_final;
    unique case (METHOD)
      per_packet_method: begin
        if (cpl_valid && cpl_final) begin
          rel_hdr  = tag.rd_hdr;
          rel_data = tag.rd_data;
        end
      end
      per_boundary_method: begin
        if (cpl_valid) begin
          if (IO_CREDIT_RULE && tag.rd_kind != cct_mem_read) begin
            rel_hdr  = 13'h0001;
            rel_data = tag.rd_data;
          end else begin
            rel_hdr  = cpl_hdr_blocks;
            rel_data = 13'(cpl_hdr_blocks << dpb_log2);
          end
        end
      end
      per_data_credit_method: begin
        if (cpl_valid) begin
          rel_hdr  = cpl_has_data ? cpl_hdr_blocks : 13'h0001;
          rel_data = cpl_has_data ? cpl_data_blocks : 13'h0000;
        end
      end
      request_limit_method: begin
        rel_hdr  = 13'h0000;
        rel_data = 13'h0000;
      end
    endcase
  end

  always_comb begin
    tag.wr_en   = req_sent && (METHOD != request_limit_method);
    tag.wr_tag  = req_tag;
    tag.wr_hdr  = need_hdr;
    tag.wr_data = need_data;
    tag.wr_kind = req_kind;
    tag.rd_tag  = cpl_tag;
  end

  always_comb begin
    next_st          = st;
    next_st.rcb_log2 = (USE_CFG_RCB && cfg_rcb_status[FUNC_SEL]) ? CCT_RCB128_LOG2 : CCT_RCB64_LOG2;
    next_st.mrs_log2 = CCT_MRS_BASE_LOG2;
    if (USE_CFG_MRS && mrs_code <= CCT_MRS_MAX_CODE) begin
      next_st.mrs_log2 = 4'(CCT_MRS_BASE_LOG2 + {1'b0, mrs_code});
    end
    next_st.request_limit = (data_pool_lim < hdr_pool_lim) ? data_pool_lim : hdr_pool_lim;
    if (METHOD == request_limit_method) begin
      // counts requests in flight; ready gates each send, so it only passes the limit when the limit drops
      next_st.outstanding_request_count = cct_sat_sub(
        {1'b0, st.outstanding_request_count} + {13'h0000, req_sent},
        {12'h000, limit_release});
    end else begin
      next_st.pending_header_credits = cct_sat_sub(
        {1'b0, st.pending_header_credits} + (req_sent ? {1'b0, need_hdr} : 14'h0000),
        rel_hdr);
      next_st.pending_data_credits = cct_sat_sub(
        {1'b0, st.pending_data_credits} + (req_sent ? {1'b0, need_data} : 14'h0000),
        rel_data);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= CCT_TOP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign outstanding_request_count = st.outstanding_request_count;
  assign request_limit             = st.request_limit;
  assign pending_header_credits    = st.pending_header_credits;
  assign pending_data_credits      = st.pending_data_credits;

  AST_RCB_CODE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> st.rcb_log2 == (($past(cfg_rcb_status[FUNC_SEL]) && USE_CFG_RCB) ? 4'h7 : 4'h6))
    else $error("boundary size does not follow status bit");

  AST_MRS_CODE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && USE_CFG_MRS && $past(mrs_code) == 3'h5 |-> st.mrs_log2 == 4'hc)
    else $error("request size code 101b is not 4096 bytes");

  AST_RESET_CLEAR: assert property (@(posedge core_clk)
    sys_rst |=> st.pending_header_credits == 13'h0000 && st.pending_data_credits == 13'h0000 &&
                st.outstanding_request_count == 13'h0000)
    else $error("counters not cleared by reset");

  AST_LIMIT_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == request_limit_method && $stable(st.request_limit)
      |-> st.outstanding_request_count <= st.request_limit)
    else $error("outstanding requests above limit");

  AST_LIMIT_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == request_limit_method && req_sent && !limit_release
      |=> st.outstanding_request_count == $past(st.outstanding_request_count) + 13'h0001)
    else $error("send did not move outstanding count by one");

  AST_LIMIT_VALUE: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.rcb_log2 == 4'h6 && st.mrs_log2 == 4'h7 && DATA_SCALE_LOG2 == 0 && $stable(st.mrs_log2)
      && $stable(st.rcb_log2) |=> st.request_limit == 13'h0020)
    else $error("limit for 128-byte requests and 64-byte boundary is not 32");

  AST_SEND_ROOM: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD != request_limit_method && req_sent
      |-> st.pending_header_credits + need_hdr < CCT_TOTAL_HDR && st.pending_data_credits + need_data < TOTAL_DATA)
    else $error("request sent without room");

  AST_PEND_ADD: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD != request_limit_method && req_sent && !cpl_valid
      |=> st.pending_header_credits == $past(st.pending_header_credits) + $past(need_hdr) &&
          st.pending_data_credits == $past(st.pending_data_credits) + $past(need_data))
    else $error("needed credits not added on send");

  AST_PACKET_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == per_packet_method && !req_sent && !(cpl_valid && cpl_final)
      |=> $stable(st.pending_header_credits) && $stable(st.pending_data_credits))
    else $error("per-packet credits released before final completion");

  AST_BOUND_NEED: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == per_boundary_method && req_valid && req_kind == cct_mem_read
      |-> need_data == 13'(need_hdr << (st.rcb_log2 - GRAN_LOG2)))
    else $error("boundary data reservation wrong");

  AST_DATA_REL: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == per_data_credit_method && cpl_valid && cpl_has_data && !req_sent
      && st.pending_data_credits >= cpl_data_blocks
      |=> st.pending_data_credits == $past(st.pending_data_credits) - $past(cpl_data_blocks))
    else $error("data credit release wrong");

  AST_HDR_REL: assert property (@(posedge core_clk) disable iff (sys_rst)
    METHOD == per_data_credit_method && cpl_valid && cpl_has_data && !req_sent
      && st.pending_header_credits >= cpl_hdr_blocks
      |=> st.pending_header_credits == $past(st.pending_header_credits) - $past(cpl_hdr_blocks))
    else $error("header credit release wrong");

endmodule : cct_tracker

/* bench/cct_core_model.sv */
`timescale 1ns/1ps
module cct_core_model
  import cct_pkg::*;
#(
  parameter bit         RCB_128  = 1'b0,
  parameter logic [2:0] MRS_CODE = 3'h0
) (
  input  wire logic                 core_clk,
  output logic      [1:0]           cfg_rcb_status,
  output logic      [15:0]          cfg_dcommand,
  input  wire logic                 req_sent,
  input  wire logic [11:0]          req_addr,
  input  wire logic [12:0]          req_size,
  input  wire cct_pkg::cct_kind_e   req_kind,
  input  wire logic [CCT_TAG_W-1:0] req_tag,
  output logic                      cpl_valid,
  output logic      [CCT_TAG_W-1:0] cpl_tag,
  output logic      [6:0]           cpl_lower_addr,
  output logic      [10:0]          cpl_length_dw,
  output logic                      cpl_has_data,
  output logic                      cpl_final
);
  // completion space held by the endpoint: 64 headers, 15872 data bytes
  localparam int HDR_SPACE  = 64;
  localparam int DATA_SPACE = 15872;
  logic      [11:0] a_tab [CCT_TAGS];
  logic      [12:0] s_tab [CCT_TAGS];
  cct_kind_e        k_tab [CCT_TAGS];
  assign cfg_rcb_status = {1'b0, RCB_128};
  assign cfg_dcommand   = {1'b0, MRS_CODE, 12'h000};
  always_ff @(posedge core_clk) begin
    if (req_sent) begin
      a_tab[req_tag] <= req_addr;
      s_tab[req_tag] <= req_size;
      k_tab[req_tag] <= req_kind;
    end
  end
  initial begin
    cpl_valid      = 1'b0;
    cpl_tag        = '0;
    cpl_lower_addr = '0;
    cpl_length_dw  = '0;
    cpl_has_data   = 1'b0;
    cpl_final      = 1'b0;
  end
  // one header pulse; fields scrambled afterwards so stale values never help
  task automatic complete(input logic [4:0] t, input logic fin, input int waits);
    logic [12:0] dw;
    repeat (waits) @(posedge core_clk);
    #1;
    dw             = (13'(a_tab[t][1:0]) + s_tab[t] + 13'h0003) >> 2;
    cpl_valid      = 1'b1;
    cpl_tag        = t;
    cpl_lower_addr = a_tab[t][6:0];
    cpl_length_dw  = dw[10:0];
    cpl_has_data   = (k_tab[t] != cct_io_write);
    cpl_final      = fin;
    @(posedge core_clk);
    #1;
    cpl_valid      = 1'b0;
    cpl_tag        = ~t;
    cpl_lower_addr = ~cpl_lower_addr;
    cpl_length_dw  = ~cpl_length_dw;
    cpl_has_data   = ~cpl_has_data;
    cpl_final      = ~fin;
  endtask : complete
endmodule : cct_core_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cct_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [12:0] size;
    cct_kind_e   kind;
    logic [12:0] hdr;
    logic [12:0] data;
  } cct_row_s;
  logic             core_clk, sys_rst, req_valid, req_ready, req_sent;
  logic [1:0]       cfg_rcb_status;
  logic [15:0]      cfg_dcommand;
  logic [11:0]      req_addr;
  logic [12:0]      req_size;
  cct_kind_e        req_kind;
  logic [4:0]       req_tag, cpl_tag;
  logic             cpl_valid, cpl_has_data, cpl_final;
  logic [6:0]       cpl_lower_addr;
  logic [10:0]      cpl_length_dw;
  logic [12:0]      o_cnt, o_lim, p_hdr, p_data;
  int               n_errors, check_count, cycles;
  // 64-byte boundary, 128-byte request size
  cct_row_s rows [6] = '{
    '{12'h07c, 13'h0008, cct_mem_read, 13'h0002, 13'h0002},
    '{12'h000, 13'h0080, cct_mem_read, 13'h0002, 13'h0008},
    '{12'h004, 13'h0004, cct_io_write, 13'h0001, 13'h0000},
    '{12'h000, 13'h0004, cct_io_read,  13'h0001, 13'h0001},
    '{12'h03f, 13'h0002, cct_mem_read, 13'h0002, 13'h0002},
    '{12'h7ff, 13'h0001, cct_mem_read, 13'h0001, 13'h0001}};
  cct_tracker #(.METHOD(per_packet_method)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg_rcb_status(cfg_rcb_status),
    .cfg_dcommand(cfg_dcommand), .req_valid(req_valid), .req_ready(req_ready),
    .req_sent(req_sent), .req_addr(req_addr), .req_size(req_size), .req_kind(req_kind),
    .req_tag(req_tag), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag),
    .cpl_lower_addr(cpl_lower_addr), .cpl_length_dw(cpl_length_dw),
    .cpl_has_data(cpl_has_data), .cpl_final(cpl_final),
    .outstanding_request_count(o_cnt), .request_limit(o_lim),
    .pending_header_credits(p_hdr), .pending_data_credits(p_data));
  cct_core_model model (
    .core_clk(core_clk), .cfg_rcb_status(cfg_rcb_status), .cfg_dcommand(cfg_dcommand),
    .req_sent(req_sent), .req_addr(req_addr), .req_size(req_size), .req_kind(req_kind),
    .req_tag(req_tag), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag),
    .cpl_lower_addr(cpl_lower_addr), .cpl_length_dw(cpl_length_dw),
    .cpl_has_data(cpl_has_data), .cpl_final(cpl_final));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // offer at edge+1, expect it taken, hold for one edge, then scramble address, size and tag
  task automatic send(input logic [11:0] a, input logic [12:0] s, input cct_kind_e k, input logic [4:0] t);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_addr  = a;
    req_size  = s;
    req_kind  = k;
    req_tag   = t;
    #1;
    check("req_sent", {12'h000, req_sent}, 13'h0001);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    req_addr  = ~a;
    req_size  = ~s;
    req_tag   = ~t;
  endtask : send
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    sys_rst   = 1'b1;
    req_valid = 1'b0;
    req_addr  = '0;
    req_size  = 13'h0001;
    req_kind  = cct_mem_read;
    req_tag   = '0;
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("pending_header_credits", p_hdr, 13'h0000);
    check("pending_data_credits", p_data, 13'h0000);
    check("request_limit", o_lim, 13'h0020);
    check("outstanding_request_count", o_cnt, 13'h0000);
    foreach (rows[i]) begin
      send(rows[i].addr, rows[i].size, rows[i].kind, 5'(i));
      check("pending_header_credits", p_hdr, rows[i].hdr);
      check("pending_data_credits", p_data, rows[i].data);
      model.complete(5'(i), 1'b0, 0);
      check("pending_header_credits", p_hdr, rows[i].hdr);
      model.complete(5'(i), 1'b1, 2);
      check("pending_header_credits", p_hdr, 13'h0000);
      check("pending_data_credits", p_data, 13'h0000);
    end
    // 63 headers fit exactly; one more must wait for the release
    send(12'h000, 13'h0fc0, cct_mem_read, 5'h07);
    check("pending_header_credits", p_hdr, 13'h003f);
    check("pending_data_credits", p_data, 13'h00fc);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_addr  = 12'h010;
    req_size  = 13'h0004;
    req_kind  = cct_mem_read;
    req_tag   = 5'h08;
    #1;
    check("req_ready", {12'h000, req_ready}, 13'h0000);
    check("req_sent", {12'h000, req_sent}, 13'h0000);
    model.complete(5'h07, 1'b1, 0);
    check("req_sent", {12'h000, req_sent}, 13'h0001);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    check("pending_header_credits", p_hdr, 13'h0001);
    check("pending_data_credits", p_data, 13'h0001);
    complete_run();
  end
endmodule : tb_top
